// File: shared/ctt_consts.svh
// Register offsets, field positions, reset values and tick divisors of the counter/timer
`ifndef CTT_CONSTS_SVH
`define CTT_CONSTS_SVH

`define CTT_OFF_LOW 8'h00
`define CTT_OFF_HIGH 8'h04
`define CTT_OFF_AUX 8'h08
`define CTT_OFF_CMD 8'h0c
`define CTT_OFF_START 8'h10
`define CTT_OFF_STOP 8'h14
`define CTT_OFF_STATUS 8'h18
`define CTT_OFF_MASK 8'h1c
`define CTT_OFF_CLEAR 8'h20
`define CTT_OFF_CSR 8'h24

`define CTT_READY_BIT 3
`define CTT_AUX_TIMER_BIT 6
`define CTT_AUX_SRC_HI 5
`define CTT_AUX_SRC_LO 4
`define CTT_CMD_TO_ON 4'ha
`define CTT_CMD_TO_OFF 4'hc
`define CTT_CSR_SEL_CT 4'hd

`define CTT_RST_BYTE 8'h00
`define CTT_RST_COUNT 16'h0000
`define CTT_ROLLOVER 16'hffff
`define CTT_PRESCALE_W 8
`define CTT_DIV16_MASK 8'h0f
`define CTT_DIV256_MASK 8'hff

`define CTT_RESP_OKAY 2'h0
`define CTT_RESP_SLVERR 2'h2

`endif

// File: shared/ctt_pkg.sv
// Types shared by the counter/timer design
package ctt_pkg;

  // Counting engine states
  typedef enum logic [1:0] {
    st_idle,
    st_run,
    st_halt
  } ctt_state_t;

  // Counter clock sources selected by auxiliary control bits 5:4
  typedef enum logic [1:0] {
    src_ext_pin,
    src_sys_clk,
    src_sys_div16,
    src_sys_div256
  } ctt_src_t;

endpackage

// File: hdl/ctt_counter_timer.sv
// Counter/timer with receive time-out mode behind an AXI4-Lite register slave
`include "ctt_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ctt_counter_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ct_ext_clk,
  input wire logic rx_char_load,
  output logic ct_out,
  output logic rx_baud16_tick,
  output logic tx_baud16_tick,
  output logic irq
);

  // Address match helper
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a[7:2] == off[7:2]);
  endfunction

  logic aw_held;
  logic [7:0] aw_addr_q;
  logic w_held;
  logic [7:0] w_data_q;
  logic w_strb0_q;
  logic wr_fire;
  logic wr_ok;
  logic rd_fire;
  logic [7:0] rd_value;
  logic rd_ok;
  logic [7:0] preset_low_byte;
  logic [7:0] preset_high_byte;
  logic [7:0] auxiliary_control_reg;
  logic [7:0] baud_clock_select_reg;
  logic [7:0] interrupt_status_reg;
  logic [7:0] interrupt_mask_reg;
  logic to_mode;
  logic load_pend;
  ctt_pkg::ctt_state_t state;
  logic [15:0] count;
  logic ct_prev;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic [`CTT_PRESCALE_W-1:0] prescale;
  logic tick;
  logic timer_mode;
  logic start_cmd;
  logic stop_cmd;
  logic to_on_cmd;
  logic to_off_cmd;
  logic clear_wr;
  logic tmr_toggle;
  logic cnt_zero_hit;
  logic restart;
  logic set_ready;
  logic clr_ready;

  // Write channel capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data_q <= 8'h00;
      w_strb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data_q <= s_axi_wdata[7:0];
      w_strb0_q <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // Writable addresses
  always_comb begin
    if (addr_hit(aw_addr_q, `CTT_OFF_LOW)) begin
      wr_ok = 1'b1;
    end else if (addr_hit(aw_addr_q, `CTT_OFF_HIGH)) begin
      wr_ok = 1'b1;
    end else if (addr_hit(aw_addr_q, `CTT_OFF_AUX)) begin
      wr_ok = 1'b1;
    end else if (addr_hit(aw_addr_q, `CTT_OFF_CMD)) begin
      wr_ok = 1'b1;
    end else if (addr_hit(aw_addr_q, `CTT_OFF_MASK)) begin
      wr_ok = 1'b1;
    end else if (addr_hit(aw_addr_q, `CTT_OFF_CLEAR)) begin
      wr_ok = 1'b1;
    end else if (addr_hit(aw_addr_q, `CTT_OFF_CSR)) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // Write response, one cycle after both channels held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CTT_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `CTT_RESP_OKAY : `CTT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; byte lane 0 carries every register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      preset_low_byte <= `CTT_RST_BYTE;
      preset_high_byte <= `CTT_RST_BYTE;
      auxiliary_control_reg <= `CTT_RST_BYTE;
      interrupt_mask_reg <= `CTT_RST_BYTE;
      baud_clock_select_reg <= `CTT_RST_BYTE;
    end else if (wr_fire && w_strb0_q) begin
      if (addr_hit(aw_addr_q, `CTT_OFF_LOW)) begin
        preset_low_byte <= w_data_q;
      end else if (addr_hit(aw_addr_q, `CTT_OFF_HIGH)) begin
        preset_high_byte <= w_data_q;
      end else if (addr_hit(aw_addr_q, `CTT_OFF_AUX)) begin
        auxiliary_control_reg <= w_data_q;
      end else if (addr_hit(aw_addr_q, `CTT_OFF_MASK)) begin
        interrupt_mask_reg <= w_data_q;
      end else if (addr_hit(aw_addr_q, `CTT_OFF_CSR)) begin
        baud_clock_select_reg <= w_data_q;
      end
    end
  end

  // Command decode from writes and reserved reads
  assign to_on_cmd = wr_fire && w_strb0_q && addr_hit(aw_addr_q, `CTT_OFF_CMD)
    && (w_data_q[7:4] == `CTT_CMD_TO_ON);
  assign to_off_cmd = wr_fire && w_strb0_q && addr_hit(aw_addr_q, `CTT_OFF_CMD)
    && (w_data_q[7:4] == `CTT_CMD_TO_OFF);
  assign clear_wr = wr_fire && w_strb0_q && addr_hit(aw_addr_q, `CTT_OFF_CLEAR);
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign start_cmd = rd_fire && addr_hit(s_axi_araddr, `CTT_OFF_START) && !to_mode;
  assign stop_cmd = rd_fire && addr_hit(s_axi_araddr, `CTT_OFF_STOP) && !to_mode;

  // Read data select; count reads show the live counter
  always_comb begin
    rd_ok = 1'b1;
    if (addr_hit(s_axi_araddr, `CTT_OFF_LOW)) begin
      rd_value = count[7:0];
    end else if (addr_hit(s_axi_araddr, `CTT_OFF_HIGH)) begin
      rd_value = count[15:8];
    end else if (addr_hit(s_axi_araddr, `CTT_OFF_AUX)) begin
      rd_value = auxiliary_control_reg;
    end else if (addr_hit(s_axi_araddr, `CTT_OFF_START)) begin
      rd_value = 8'h00;
    end else if (addr_hit(s_axi_araddr, `CTT_OFF_STOP)) begin
      rd_value = 8'h00;
    end else if (addr_hit(s_axi_araddr, `CTT_OFF_STATUS)) begin
      rd_value = interrupt_status_reg;
    end else if (addr_hit(s_axi_araddr, `CTT_OFF_MASK)) begin
      rd_value = interrupt_mask_reg;
    end else if (addr_hit(s_axi_araddr, `CTT_OFF_CSR)) begin
      rd_value = baud_clock_select_reg;
    end else begin
      rd_value = 8'h00;
      rd_ok = 1'b0;
    end
  end

  // Read answer, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CTT_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_value};
      s_axi_rresp <= rd_ok ? `CTT_RESP_OKAY : `CTT_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // External counter clock pin: two-stage synchroniser, then edge detect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= ct_ext_clk;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // Free-running prescaler for the divided system clock sources
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 8'h01;
    end
  end

  // Counter clock enable chosen by auxiliary bits 5:4
  always_comb begin
    case (ctt_pkg::ctt_src_t'(auxiliary_control_reg[`CTT_AUX_SRC_HI:`CTT_AUX_SRC_LO]))
      ctt_pkg::src_ext_pin: tick = ext_sync && !ext_prev;
      ctt_pkg::src_sys_clk: tick = 1'b1;
      ctt_pkg::src_sys_div16: tick = ((prescale & `CTT_DIV16_MASK) == `CTT_DIV16_MASK);
      default: tick = (prescale == `CTT_DIV256_MASK);
    endcase
  end

  // Mode and event terms
  assign timer_mode = auxiliary_control_reg[`CTT_AUX_TIMER_BIT] && !to_mode;
  assign tmr_toggle = (state == ctt_pkg::st_run) && tick && timer_mode && (count <= 16'h0001);
  assign cnt_zero_hit = (state == ctt_pkg::st_run) && tick && !timer_mode && !(to_mode && load_pend)
    && (count == 16'h0001);
  assign restart = (state == ctt_pkg::st_halt) && tick;
  assign set_ready = cnt_zero_hit || (tmr_toggle && ct_out);
  assign clr_ready = stop_cmd || to_on_cmd || (restart && to_mode)
    || (clear_wr && w_data_q[`CTT_READY_BIT]);

  // Time-out mode flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      to_mode <= 1'b0;
    end else if (to_on_cmd) begin
      to_mode <= 1'b1;
    end else if (to_off_cmd) begin
      to_mode <= 1'b0;
    end
  end

  // Receive load pulse held until the next counter clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_pend <= 1'b0;
    end else if (!to_mode) begin
      load_pend <= 1'b0;
    end else begin
      load_pend <= rx_char_load || (load_pend && !tick);
    end
  end

  // Counting engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ctt_pkg::st_idle;
      count <= `CTT_RST_COUNT;
      ct_out <= 1'b1;
    end else if (to_on_cmd) begin
      state <= ctt_pkg::st_idle;
      ct_out <= 1'b1;
    end else if (to_off_cmd) begin
      state <= ctt_pkg::st_idle;
    end else if (start_cmd) begin
      count <= {preset_high_byte, preset_low_byte};
      state <= ctt_pkg::st_run;
      ct_out <= 1'b1;
    end else if (stop_cmd && !timer_mode) begin
      state <= ctt_pkg::st_idle;
    end else if (tick) begin
      case (state)
        ctt_pkg::st_run: begin
          if (to_mode && load_pend) begin
            state <= ctt_pkg::st_halt;
          end else if (timer_mode) begin
            if (count <= 16'h0001) begin
              count <= {preset_high_byte, preset_low_byte};
              ct_out <= !ct_out;
            end else begin
              count <= count - 16'h0001;
            end
          end else if (count == 16'h0001) begin
            count <= 16'h0000;
            ct_out <= 1'b0;
            if (to_mode) begin
              state <= ctt_pkg::st_idle;
            end
          end else if (count == 16'h0000) begin
            count <= `CTT_ROLLOVER;
          end else begin
            count <= count - 16'h0001;
          end
        end
        ctt_pkg::st_halt: begin
          count <= {preset_high_byte, preset_low_byte};
          state <= ctt_pkg::st_run;
          ct_out <= 1'b1;
        end
        default: begin
          if (to_mode && load_pend) begin
            state <= ctt_pkg::st_halt;
          end
        end
      endcase
    end
  end

  // Counter ready status; a set beats any clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_status_reg <= `CTT_RST_BYTE;
    end else if (set_ready) begin
      interrupt_status_reg[`CTT_READY_BIT] <= 1'b1;
    end else if (clr_ready) begin
      interrupt_status_reg[`CTT_READY_BIT] <= 1'b0;
    end
  end

  // Level interrupt from enabled status bits
  assign irq = |(interrupt_status_reg & interrupt_mask_reg);

  // 16x baud ticks on each rising edge of the timer output, for each side whose select nibble is hd
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ct_prev <= 1'b1;
      rx_baud16_tick <= 1'b0;
      tx_baud16_tick <= 1'b0;
    end else begin
      ct_prev <= ct_out;
      rx_baud16_tick <= ct_out && !ct_prev && (baud_clock_select_reg[3:0] == `CTT_CSR_SEL_CT);
      tx_baud16_tick <= ct_out && !ct_prev && (baud_clock_select_reg[7:4] == `CTT_CSR_SEL_CT);
    end
  end

  // Checks
  property p_stop_clears;
    @(posedge aclk) disable iff (!aresetn)
      (stop_cmd && !set_ready) |=> !interrupt_status_reg[`CTT_READY_BIT];
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("stop left ready set");

  property p_timer_survives_stop;
    @(posedge aclk) disable iff (!aresetn)
      (stop_cmd && timer_mode && state == ctt_pkg::st_run) |=> (state == ctt_pkg::st_run);
  endproperty
  a_timer_survives_stop: assert property (p_timer_survives_stop) else $error("timer stopped");

  property p_baud_tick;
    @(posedge aclk) disable iff (!aresetn)
      ($rose(ct_out) && baud_clock_select_reg[3:0] == `CTT_CSR_SEL_CT) |=> rx_baud16_tick;
  endproperty
  a_baud_tick: assert property (p_baud_tick) else $error("missing rx baud tick");

  property p_count_zero;
    @(posedge aclk) disable iff (!aresetn)
      (cnt_zero_hit && !to_on_cmd && !to_off_cmd && !start_cmd && !stop_cmd)
      |=> (count == 16'h0000) && !ct_out && interrupt_status_reg[`CTT_READY_BIT];
  endproperty
  a_count_zero: assert property (p_count_zero) else $error("zero not reached cleanly");

  property p_wrap;
    @(posedge aclk) disable iff (!aresetn)
      (state == ctt_pkg::st_run && tick && !timer_mode && !to_mode && count == 16'h0000
        && !start_cmd && !stop_cmd && !to_on_cmd && !to_off_cmd) |=> (count == `CTT_ROLLOVER);
  endproperty
  a_wrap: assert property (p_wrap) else $error("no rollover");

  property p_live_read;
    @(posedge aclk) disable iff (!aresetn)
      (rd_fire && addr_hit(s_axi_araddr, `CTT_OFF_LOW)) |=> (s_axi_rdata[7:0] == $past(count[7:0]));
  endproperty
  a_live_read: assert property (p_live_read) else $error("count read mismatch");

  property p_to_blocks_start;
    @(posedge aclk) disable iff (!aresetn)
      (to_mode && !load_pend && state == ctt_pkg::st_idle && !to_off_cmd && !to_on_cmd)
      |=> (state == ctt_pkg::st_idle);
  endproperty
  a_to_blocks_start: assert property (p_to_blocks_start) else $error("idle left without char");

  sequence s_halt_tick;
    (state == ctt_pkg::st_halt) && tick && !to_on_cmd && !to_off_cmd && !start_cmd;
  endsequence
  sequence s_reloaded;
    (state == ctt_pkg::st_run) && (count == $past({preset_high_byte, preset_low_byte}));
  endsequence
  property p_reload;
    @(posedge aclk) disable iff (!aresetn)
      s_halt_tick |=> s_reloaded;
  endproperty
  a_reload: assert property (p_reload) else $error("reload after halt failed");

  property p_expiry_irq;
    @(posedge aclk) disable iff (!aresetn)
      (cnt_zero_hit && to_mode && !to_on_cmd && !to_off_cmd) |=> (irq == interrupt_mask_reg[`CTT_READY_BIT]);
  endproperty
  a_expiry_irq: assert property (p_expiry_irq) else $error("expiry interrupt wrong");

  property p_restart_clears;
    @(posedge aclk) disable iff (!aresetn)
      (s_halt_tick ##0 to_mode) |=> !interrupt_status_reg[`CTT_READY_BIT] && !irq;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("restart kept ready");

  property p_to_on;
    @(posedge aclk) disable iff (!aresetn)
      (to_on_cmd && !set_ready) |=> to_mode && (state == ctt_pkg::st_idle) && !interrupt_status_reg[`CTT_READY_BIT];
  endproperty
  a_to_on: assert property (p_to_on) else $error("time-out on misbehaved");

  property p_start_load;
    @(posedge aclk) disable iff (!aresetn)
      (start_cmd && !to_on_cmd && !to_off_cmd) |=> (count == $past({preset_high_byte, preset_low_byte}));
  endproperty
  a_start_load: assert property (p_start_load) else $error("start did not load");

  property p_timer_fall;
    @(posedge aclk) disable iff (!aresetn)
      (tmr_toggle && ct_out && !start_cmd && !to_on_cmd && !to_off_cmd)
      |=> !ct_out && interrupt_status_reg[`CTT_READY_BIT];
  endproperty
  a_timer_fall: assert property (p_timer_fall) else $error("timer fall lost");

  property p_load_pending;
    @(posedge aclk) disable iff (!aresetn)
      (rx_char_load && to_mode) |=> load_pend;
  endproperty
  a_load_pending: assert property (p_load_pending) else $error("char load lost");

endmodule

`default_nettype wire

// File: dv/ctt_host_model.sv
// Host bus master model driving the counter/timer register slave
`timescale 1ns/1ps
`default_nettype none
module ctt_host_model (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Quiet bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Write: both channels offered, each dropped when taken, then the response
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_t) begin
      @(posedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      resp = s_axi_bresp;
      if (aw_t) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (w_t) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~s_axi_wdata;
      end
    end
    s_axi_bready <= 1'b0;
    // Idle edge so a following call starts in a fresh time step
    @(posedge aclk);
  endtask
  // Read: address held until taken, data taken with rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar_t, r_t;
    r_t = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_t) begin
      @(posedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      if (ar_t) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end
    s_axi_rready <= 1'b0;
    // Idle edge so a following call starts in a fresh time step
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// File: dv/counter_timer_rx_timeout_tb.sv
// Self-checking bench for the counter/timer with receive time-out
`timescale 1ns/1ps
`default_nettype none
`include "ctt_consts.svh"
module counter_timer_rx_timeout_tb;
  logic aclk, aresetn, ct_ext_clk, rx_char_load, ct_out, rx_baud16_tick, tx_baud16_tick, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic ct_d1, ct_d2, mon, sel_rx, sel_tx;
  int err_total, n_checks, n;

  ctt_counter_timer i_ctt_counter_timer (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ct_ext_clk(ct_ext_clk),
    .rx_char_load(rx_char_load), .ct_out(ct_out), .rx_baud16_tick(rx_baud16_tick),
    .tx_baud16_tick(tx_baud16_tick), .irq(irq));

  ctt_host_model i_ctt_host_model (.aclk(aclk),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // Clock, 4 ns period
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Register write with expected response
  task automatic wreg(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    i_ctt_host_model.wr(a, d, r);
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  // Register read with expected data and response
  task automatic rreg(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] r;
    i_ctt_host_model.rd(a, v, r);
    chk("rresp", {30'h0, er}, {30'h0, r});
    chk("rdata", {24'h0, e}, v);
  endtask

  // Start or stop read, data not judged
  task automatic cmd(input logic [7:0] a);
    logic [31:0] v;
    logic [1:0] r;
    i_ctt_host_model.rd(a, v, r);
    chk("cmd_resp", {30'h0, `CTT_RESP_OKAY}, {30'h0, r});
  endtask

  // Bounded wait for irq or ct_out to reach a level
  task automatic wt(input bit is_irq, input logic v, input int lim);
    int k;
    logic s;
    k = 0;
    s = is_irq ? irq : ct_out;
    while (s !== v && k < lim) begin
      @(posedge aclk);
      s = is_irq ? irq : ct_out;
      k++;
    end
    chk(is_irq ? "irq" : "ct_out", {31'h0, v}, {31'h0, s});
  endtask

  // Edges until ct_out shows a level
  task automatic lvl(input logic v, output int k);
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (ct_out !== v && k < 100);
  endtask

  // One-cycle character load pulse
  task automatic pulse();
    rx_char_load <= 1'b1;
    @(posedge aclk);
    rx_char_load <= 1'b0;
  endtask

  // Baud ticks one cycle after each rise of the output when selected
  always @(posedge aclk) begin
    ct_d2 <= ct_d1;
    ct_d1 <= ct_out;
    if (mon) begin
      chk("rx_tick", {31'h0, sel_rx && ct_d1 && !ct_d2}, {31'h0, rx_baud16_tick});
      chk("tx_tick", {31'h0, sel_tx && ct_d1 && !ct_d2}, {31'h0, tx_baud16_tick});
    end
  end

  // Reset values, read/write registers and refused addresses
  task automatic t_regs();
    wt(0, 1'b1, 0);
    wt(1, 1'b0, 0);
    rreg(`CTT_OFF_STATUS, 8'h00, `CTT_RESP_OKAY);
    wreg(`CTT_OFF_AUX, 8'h35, `CTT_RESP_OKAY);
    rreg(`CTT_OFF_AUX, 8'h35, `CTT_RESP_OKAY);
    wreg(`CTT_OFF_CSR, 8'hdd, `CTT_RESP_OKAY);
    rreg(`CTT_OFF_CSR, 8'hdd, `CTT_RESP_OKAY);
    rreg(`CTT_OFF_CMD, 8'h00, `CTT_RESP_SLVERR);
    rreg(8'h28, 8'h00, `CTT_RESP_SLVERR);
    wreg(8'h28, 8'h5a, `CTT_RESP_SLVERR);
  endtask

  // Live count with external clock source
  task automatic t_live();
    wreg(`CTT_OFF_AUX, 8'h00, `CTT_RESP_OKAY);
    wreg(`CTT_OFF_LOW, 8'h34, `CTT_RESP_OKAY);
    wreg(`CTT_OFF_HIGH, 8'h12, `CTT_RESP_OKAY);
    cmd(`CTT_OFF_START);
    rreg(`CTT_OFF_LOW, 8'h34, `CTT_RESP_OKAY);
    rreg(`CTT_OFF_HIGH, 8'h12, `CTT_RESP_OKAY);
    repeat (4) @(posedge aclk);
    ct_ext_clk <= 1'b1;
    repeat (4) @(posedge aclk);
    ct_ext_clk <= 1'b0;
    repeat (6) @(posedge aclk);
    rreg(`CTT_OFF_LOW, 8'h33, `CTT_RESP_OKAY);
  endtask

  // Counter mode expiry, wrap, masking, clear and stop
  task automatic t_count();
    wreg(`CTT_OFF_MASK, 8'h00, `CTT_RESP_OKAY);
    wreg(`CTT_OFF_AUX, 8'h10, `CTT_RESP_OKAY);
    wreg(`CTT_OFF_LOW, 8'h05, `CTT_RESP_OKAY);
    wreg(`CTT_OFF_HIGH, 8'h00, `CTT_RESP_OKAY);
    cmd(`CTT_OFF_START);
    wt(0, 1'b0, 20);
    rreg(`CTT_OFF_STATUS, 8'h08, `CTT_RESP_OKAY);
    wt(1, 1'b0, 0);
    wreg(`CTT_OFF_MASK, 8'h08, `CTT_RESP_OKAY);
    wt(1, 1'b1, 2);
    rreg(`CTT_OFF_HIGH, 8'hff, `CTT_RESP_OKAY);
    wt(0, 1'b0, 0);
    wreg(`CTT_OFF_CLEAR, 8'h08, `CTT_RESP_OKAY);
    rreg(`CTT_OFF_STATUS, 8'h00, `CTT_RESP_OKAY);
    wt(1, 1'b0, 0);
    cmd(`CTT_OFF_START);
    wt(0, 1'b0, 20);
    cmd(`CTT_OFF_STOP);
    rreg(`CTT_OFF_STATUS, 8'h00, `CTT_RESP_OKAY);
  endtask

  // Divided system clock sources
  task automatic t_src();
    for (int i = 2; i < 4; i++) begin
      wreg(`CTT_OFF_AUX, {2'b00, 2'(i), 4'h0}, `CTT_RESP_OKAY);
      wreg(`CTT_OFF_LOW, 8'h02, `CTT_RESP_OKAY);
      cmd(`CTT_OFF_START);
      repeat (i == 2 ? 10 : 200) @(posedge aclk);
      wt(0, 1'b1, 0);
      wt(0, 1'b0, i == 2 ? 40 : 600);
    end
  endtask

  // Timer square wave, stop, baud tick selection
  task automatic t_timer();
    wreg(`CTT_OFF_AUX, 8'h50, `CTT_RESP_OKAY);
    wreg(`CTT_OFF_LOW, 8'h04, `CTT_RESP_OKAY);
    sel_rx <= 1'b1;
    sel_tx <= 1'b1;
    cmd(`CTT_OFF_START);
    mon <= 1'b1;
    lvl(1'b0, n);
    lvl(1'b1, n);
    chk("low_half", 32'd4, n);
    lvl(1'b0, n);
    chk("high_half", 32'd4, n);
    cmd(`CTT_OFF_STOP);
    lvl(1'b0, n);
    lvl(1'b1, n);
    chk("half_after_stop", 32'd4, n);
    mon <= 1'b0;
    wreg(`CTT_OFF_CSR, 8'hd0, `CTT_RESP_OKAY);
    sel_rx <= 1'b0;
    repeat (3) @(posedge aclk);
    mon <= 1'b1;
    repeat (40) @(posedge aclk);
    mon <= 1'b0;
  endtask

  // Receive time-out mode
  task automatic t_tmo();
    wreg(`CTT_OFF_AUX, 8'h10, `CTT_RESP_OKAY);
    wreg(`CTT_OFF_LOW, 8'h14, `CTT_RESP_OKAY);
    wreg(`CTT_OFF_CMD, 8'ha3, `CTT_RESP_OKAY);
    rreg(`CTT_OFF_STATUS, 8'h00, `CTT_RESP_OKAY);
    repeat (30) @(posedge aclk);
    rreg(`CTT_OFF_STATUS, 8'h00, `CTT_RESP_OKAY);
    pulse();
    repeat (16) @(posedge aclk);
    wt(1, 1'b0, 0);
    wt(1, 1'b1, 20);
    pulse();
    wt(1, 1'b0, 5);
    rreg(`CTT_OFF_STATUS, 8'h00, `CTT_RESP_OKAY);
    wt(1, 1'b1, 40);
    cmd(`CTT_OFF_STOP);
    rreg(`CTT_OFF_STATUS, 8'h08, `CTT_RESP_OKAY);
    cmd(`CTT_OFF_START);
    repeat (4) @(posedge aclk);
    wt(0, 1'b0, 0);
    wreg(`CTT_OFF_CMD, 8'hc0, `CTT_RESP_OKAY);
    cmd(`CTT_OFF_START);
    wt(0, 1'b1, 3);
  endtask

  // Main sequence
  initial begin
    {aresetn, ct_ext_clk, rx_char_load, mon, sel_rx, sel_tx} = '0;
    {ct_d1, ct_d2} = 2'b11;
    err_total = 0;
    n_checks = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_live();
    t_count();
    t_src();
    t_timer();
    t_tmo();
    close_out();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
